// ### common/sls_clk_if.sv
// configuration and clock levels between sequencer and clock generator
`timescale 1ns/1ps
interface sls_clk_if;
  logic [3:0] freq_sel;
  logic spread_en;
  logic run;
  logic cpu_level;
  logic pci_level;
  modport cfg (output freq_sel, output spread_en, output run, input cpu_level, input pci_level);
  modport gen (input freq_sel, input spread_en, input run, output cpu_level, output pci_level);
endinterface : sls_clk_if

// ### common/sls_pkg.sv
// package of constants for the strap latch sequencer
// Operation
// R1 - 2 ms selection period before clock outputs
// R2 - dual-purpose pins three-stated during selection
// R3 - latch each pin level at period end
// R4 - enable pin drivers only after latching
// R5 - timer starts at supply-good detection
// R6 - latched straps cleared only by power cycle
// R7 - low strap reads 0, high reads 1
// R8 - first cpu clock cycle may be short
// R9 - thirteen buffered copies of fanout input
// R10 - buffered copies off during power down
// R11 - spread applies to cpu and pci clocks
// R12 - frequency straps choose cpu/pci rate
// R13 - mode strap picks reference out or halt
// R14 - power down: complement hi-z, others low
// R15 - latched straps presented as stable config
package sls_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SELECT_TIME_MS = 2;
  localparam int unsigned SELECT_TIME_NS = SELECT_TIME_MS * 1000000;
  localparam int unsigned SELECT_CYCLES = (SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NUM_STRAPS = 5;
  localparam int unsigned NUM_FANOUT = 13;
  localparam int unsigned NUM_PCI = 4;
  // strap pin positions
  localparam int unsigned FS0_IDX = 0;
  localparam int unsigned FS1_IDX = 1;
  localparam int unsigned FS2_IDX = 2;
  localparam int unsigned FS3_IDX = 3;
  localparam int unsigned MODE_IDX = 4;
  // apb map
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int unsigned CTRL_SPREAD_BIT = 0;
  localparam int unsigned CTRL_USB24_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned STAT_STRAP_LSB = 1;
  localparam int unsigned STAT_PD_BIT = 6;
  localparam int unsigned STAT_HALT_BIT = 7;
  // divider model of the synthesiser
  localparam logic [7:0] CPU_HALF_BASE = 8'h14;
  localparam logic [1:0] PCI_RATIO = 2'h3;
  localparam logic [7:0] REF_HALF = 8'h07;
  localparam logic [7:0] USB_HALF = 8'h03;
  typedef enum logic [1:0] {
    SLS_SELECT = 2'b00,
    SLS_LATCH = 2'b01,
    SLS_RUN = 2'b10
  } sls_state_t;
endpackage : sls_pkg

// ### logic/sls_clk_gen.sv
// cpu and pci clock level generator with optional spread dither
`timescale 1ns/1ps
module sls_clk_gen (
  input wire logic core_clk,
  input wire logic rst,
  sls_clk_if.gen clk_bus
);
  logic [7:0] cpu_cnt;
  logic [7:0] next_cpu_cnt;
  logic [1:0] pci_cnt;
  logic [1:0] next_pci_cnt;
  logic cpu_level;
  logic next_cpu_level;
  logic pci_level;
  logic next_pci_level;
  logic dither;
  logic next_dither;
  logic [7:0] half;

  always_comb begin
    // straps pick the divider, dither stretches alternate half periods
    half = sls_pkg::CPU_HALF_BASE - {4'h0, clk_bus.freq_sel} + {7'h0, dither}; // R12 R11
    next_cpu_cnt = cpu_cnt;
    next_pci_cnt = pci_cnt;
    next_cpu_level = cpu_level;
    next_pci_level = pci_level;
    next_dither = dither & clk_bus.spread_en; // R11
    if (!clk_bus.run) begin
      next_cpu_cnt = 8'h00;
      next_pci_cnt = 2'h0;
      next_cpu_level = 1'b0;
      next_pci_level = 1'b0;
      next_dither = 1'b0;
    end else if (cpu_cnt >= half - 8'h01) begin
      next_cpu_cnt = 8'h00;
      next_cpu_level = ~cpu_level;
      next_dither = ~dither & clk_bus.spread_en; // R11
      if (pci_cnt == sls_pkg::PCI_RATIO - 2'h1) begin
        next_pci_cnt = 2'h0;
        next_pci_level = ~pci_level;
      end else begin
        next_pci_cnt = pci_cnt + 2'h1;
      end
    end else begin
      next_cpu_cnt = cpu_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_cnt <= 8'h00;
      pci_cnt <= 2'h0;
      cpu_level <= 1'b0;
      pci_level <= 1'b0;
      dither <= 1'b0;
    end else begin
      cpu_cnt <= next_cpu_cnt;
      pci_cnt <= next_pci_cnt;
      cpu_level <= next_cpu_level;
      pci_level <= next_pci_level;
      dither <= next_dither;
    end
  end

  assign clk_bus.cpu_level = cpu_level;
  assign clk_bus.pci_level = pci_level;

  chk_idle_quiet: assert property (@(posedge core_clk) disable iff (rst) // R14
    !clk_bus.run |=> !cpu_level && !pci_level) else $error("clock levels not quiet when stopped");
  chk_spread_off: assert property (@(posedge core_clk) disable iff (rst) // R11
    !clk_bus.spread_en |=> !dither) else $error("dither active with spread disabled");
endmodule : sls_clk_gen

// ### logic/strap_latch_sequencer.sv
// power-on strap sampling sequencer with clock output control and apb status
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module strap_latch_sequencer #(
  parameter int unsigned SELECT_CYCLES = sls_pkg::SELECT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] dual_pin_in,
  output logic [4:0] dual_pin_out,
  output logic [4:0] dual_pin_oe,
  input wire logic shared_pin_in,
  output logic reference_clock_out,
  output logic reference_clock_oe,
  input wire logic power_down_n,
  input wire logic fanout_clock_in,
  output logic [12:0] fanout_clock_copies,
  output logic cpu_clock_true,
  output logic cpu_clock_complement,
  output logic cpu_clock_complement_oe,
  output logic cpu_chipset_clock,
  output logic [3:0] pci_clock_out,
  output logic [3:0] freq_select_straps,
  output logic mode_strap,
  output logic straps_valid
);
  sls_clk_if clk_bus ();

  // two-flop synchronisers for pins
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic pd_s1;
  logic pd_s2;
  logic halt_s1;
  logic halt_s2;
  logic fan_s1;
  logic fan_s2;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
      halt_s1 <= 1'b1;
      halt_s2 <= 1'b1;
      fan_s1 <= 1'b0;
      fan_s2 <= 1'b0;
    end else begin
      pin_s1 <= dual_pin_in;
      pin_s2 <= pin_s1;
      pd_s1 <= power_down_n;
      pd_s2 <= pd_s1;
      halt_s1 <= shared_pin_in;
      halt_s2 <= halt_s1;
      fan_s1 <= fanout_clock_in;
      fan_s2 <= fan_s1;
    end
  end

  // selection timer and strap latch; rst is the power-on detector
  sls_pkg::sls_state_t state;
  sls_pkg::sls_state_t next_state;
  logic [31:0] sel_cnt;
  logic [31:0] next_sel_cnt;
  logic [4:0] straps;
  logic [4:0] next_straps;
  logic done;
  logic next_done;

  always_comb begin
    next_state = state;
    next_sel_cnt = sel_cnt;
    next_straps = straps; // R6
    next_done = done;
    unique case (state)
      sls_pkg::SLS_SELECT: begin
        if (sel_cnt == SELECT_CYCLES - 1) begin // R1
          next_state = sls_pkg::SLS_LATCH;
          next_straps = pin_s2; // R3 R7
          next_done = 1'b1;
        end else begin
          next_sel_cnt = sel_cnt + 32'h1; // R5
        end
      end
      sls_pkg::SLS_LATCH: next_state = sls_pkg::SLS_RUN; // R4
      sls_pkg::SLS_RUN: next_state = sls_pkg::SLS_RUN;
      default: next_state = sls_pkg::SLS_SELECT;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= sls_pkg::SLS_SELECT;
      sel_cnt <= 32'h0;
      straps <= 5'h00;
      done <= 1'b0;
    end else begin
      state <= next_state;
      sel_cnt <= next_sel_cnt;
      straps <= next_straps;
      done <= next_done;
    end
  end

  // apb slave, one wait state
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] status;
  logic halt_active;

  always_comb begin
    status = 32'h0;
    status[sls_pkg::STAT_DONE_BIT] = done;
    status[sls_pkg::STAT_STRAP_LSB +: 5] = straps;
    status[sls_pkg::STAT_PD_BIT] = ~pd_s2;
    status[sls_pkg::STAT_HALT_BIT] = halt_active;
    next_ctrl = ctrl;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_pready = psel & penable & ~pready;
    if (psel && penable && !pready) begin
      next_prdata = 32'h0;
      next_pslverr = 1'b0;
      if (paddr == sls_pkg::CTRL_OFFSET) begin
        next_prdata = {30'h0, ctrl};
      end else if (paddr == sls_pkg::STATUS_OFFSET) begin
        next_prdata = status;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (psel && penable && pready && pwrite && pstrb[0] && paddr == sls_pkg::CTRL_OFFSET) begin
      next_ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= sls_pkg::CTRL_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // clock generator hookup
  logic run;
  assign run = (state == sls_pkg::SLS_RUN);
  assign clk_bus.freq_sel = straps[sls_pkg::FS3_IDX:sls_pkg::FS0_IDX]; // R12 R15
  assign clk_bus.spread_en = ctrl[sls_pkg::CTRL_SPREAD_BIT]; // R11
  assign clk_bus.run = run & pd_s2;

  sls_clk_gen u_clk_gen (
    .core_clk(core_clk),
    .rst(rst),
    .clk_bus(clk_bus)
  );

  // reference and usb dividers
  logic [7:0] ref_cnt;
  logic [7:0] next_ref_cnt;
  logic ref_level;
  logic next_ref_level;
  logic [7:0] usb_cnt;
  logic [7:0] next_usb_cnt;
  logic usb_level;
  logic next_usb_level;
  logic usb24_level;
  logic next_usb24_level;

  always_comb begin
    next_ref_cnt = ref_cnt + 8'h01;
    next_ref_level = ref_level;
    next_usb_cnt = usb_cnt + 8'h01;
    next_usb_level = usb_level;
    next_usb24_level = usb24_level;
    if (ref_cnt == sls_pkg::REF_HALF - 8'h01) begin
      next_ref_cnt = 8'h00;
      next_ref_level = ~ref_level;
    end
    if (usb_cnt == sls_pkg::USB_HALF - 8'h01) begin
      next_usb_cnt = 8'h00;
      next_usb_level = ~usb_level;
      if (!usb_level) begin
        next_usb24_level = ~usb24_level;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_cnt <= 8'h00;
      ref_level <= 1'b0;
      usb_cnt <= 8'h00;
      usb_level <= 1'b0;
      usb24_level <= 1'b0;
    end else begin
      ref_cnt <= next_ref_cnt;
      ref_level <= next_ref_level;
      usb_cnt <= next_usb_cnt;
      usb_level <= next_usb_level;
      usb24_level <= next_usb24_level;
    end
  end

  // registered pin drivers
  logic [4:0] next_dual_out;
  logic [4:0] next_dual_oe;
  logic next_ref_out;
  logic next_ref_oe;
  logic next_cpu_t;
  logic next_cpu_c;
  logic next_cpu_c_oe;
  logic next_cpu_cs;
  logic [3:0] next_pci;
  logic [12:0] next_fanout;
  logic cpu_on;

  assign halt_active = done & ~straps[sls_pkg::MODE_IDX] & ~halt_s2; // R13

  always_comb begin
    // first enabled cpu phase may be short, no attempt to align it
    cpu_on = run & pd_s2 & ~halt_active; // R8 R14
    next_dual_oe = {5{run}}; // R2 R4
    next_dual_out = 5'h00;
    if (pd_s2) begin // R14
      next_dual_out[sls_pkg::FS0_IDX] = ref_level;
      next_dual_out[sls_pkg::FS1_IDX] = clk_bus.pci_level;
      next_dual_out[sls_pkg::FS2_IDX] = usb_level;
      next_dual_out[sls_pkg::FS3_IDX] = ctrl[sls_pkg::CTRL_USB24_BIT] ? usb24_level : usb_level;
      next_dual_out[sls_pkg::MODE_IDX] = clk_bus.pci_level;
    end
    next_ref_oe = run & straps[sls_pkg::MODE_IDX]; // R13
    next_ref_out = ref_level & pd_s2;
    next_cpu_t = cpu_on & clk_bus.cpu_level;
    next_cpu_cs = cpu_on & clk_bus.cpu_level;
    next_cpu_c = cpu_on & ~clk_bus.cpu_level;
    next_cpu_c_oe = cpu_on; // R14
    next_pci = {sls_pkg::NUM_PCI{clk_bus.pci_level & pd_s2}}; // R11
  end

  genvar gi;
  generate
    for (gi = 0; gi < sls_pkg::NUM_FANOUT; gi++) begin : g_fanout
      assign next_fanout[gi] = fan_s2 & pd_s2; // R9 R10
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dual_pin_out <= 5'h00;
      dual_pin_oe <= 5'h00;
      reference_clock_out <= 1'b0;
      reference_clock_oe <= 1'b0;
      cpu_clock_true <= 1'b0;
      cpu_clock_complement <= 1'b0;
      cpu_clock_complement_oe <= 1'b0;
      cpu_chipset_clock <= 1'b0;
      pci_clock_out <= 4'h0;
      fanout_clock_copies <= 13'h0000;
      freq_select_straps <= 4'h0;
      mode_strap <= 1'b0;
      straps_valid <= 1'b0;
    end else begin
      dual_pin_out <= next_dual_out;
      dual_pin_oe <= next_dual_oe;
      reference_clock_out <= next_ref_out;
      reference_clock_oe <= next_ref_oe;
      cpu_clock_true <= next_cpu_t;
      cpu_clock_complement <= next_cpu_c;
      cpu_clock_complement_oe <= next_cpu_c_oe;
      cpu_chipset_clock <= next_cpu_cs;
      pci_clock_out <= next_pci;
      fanout_clock_copies <= next_fanout;
      freq_select_straps <= straps[sls_pkg::FS3_IDX:sls_pkg::FS0_IDX]; // R15
      mode_strap <= straps[sls_pkg::MODE_IDX];
      straps_valid <= done;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_select_length: assert property ($rose(done) |-> $past(sel_cnt) == SELECT_CYCLES - 1) // R1 R5
    else $error("selection period length wrong");
  chk_pins_tristated: assert property (state != sls_pkg::SLS_RUN |=> dual_pin_oe == 5'h00) // R2
    else $error("dual pin driven during selection");
  chk_latch_value: assert property ((state == sls_pkg::SLS_SELECT && next_state == sls_pkg::SLS_LATCH) // R3
    |=> straps == $past(pin_s2)) else $error("strap latch missed pin level");
  chk_oe_after_latch: assert property ($rose(dual_pin_oe[0]) |-> $past(done, 2)) // R4
    else $error("pin driver enabled before latch");
  chk_straps_frozen: assert property (done |=> done && $stable(straps)) // R6
    else $error("latched straps changed");
  chk_fanout_copy: assert property (pd_s2 |=> fanout_clock_copies == {13{$past(fan_s2)}}) // R9
    else $error("fanout copies differ from input");
  chk_fanout_off: assert property (!pd_s2 |=> fanout_clock_copies == 13'h0000) // R10
    else $error("fanout active in power down");
  chk_powerdown_pins: assert property (!pd_s2 |=> !cpu_clock_complement_oe && !cpu_clock_true // R14
    && dual_pin_out == 5'h00) else $error("power down output state wrong");
  chk_halt_mode: assert property (halt_active |=> !cpu_clock_true && !cpu_chipset_clock // R13
    && !reference_clock_oe) else $error("cpu halt input not honoured");
endmodule : strap_latch_sequencer

// ### testbench/sls_strap_board.sv
// board model: strap resistors, halt driver and clock loads on the shared pins
`timescale 1ns/1ps
module sls_strap_board (
  input wire logic [4:0] pull_level,
  input wire logic halt_n,
  input wire logic [4:0] dual_pin_out,
  input wire logic [4:0] dual_pin_oe,
  input wire logic reference_clock_out,
  input wire logic reference_clock_oe,
  output logic [4:0] dual_pin_in,
  output logic shared_pin_in
);
  // a three-stated pin settles to its strap rail, a driven pin shows the device
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      dual_pin_in[i] = dual_pin_oe[i] ? dual_pin_out[i] : pull_level[i];
    end
  end
  // halt line rests on its pull-up unless the board pulls it low or the device drives the reference clock on it
  assign shared_pin_in = reference_clock_oe ? reference_clock_out : halt_n;
endmodule : sls_strap_board

// ### testbench/strap_latch_sequencer_tb.sv
// self-checking bench for the strap latch sequencer
`timescale 1ns/1ps
module strap_latch_sequencer_tb;
  localparam int unsigned SEL = 20;
  typedef struct packed {logic pdn; logic fin; logic [12:0] copies; logic cmp_oe;} sls_row_t;
  sls_row_t rows [5] = '{'{1'b1, 1'b1, 13'h1fff, 1'b1}, '{1'b1, 1'b0, 13'h0000, 1'b1},
    '{1'b0, 1'b1, 13'h0000, 1'b0}, '{1'b0, 1'b0, 13'h0000, 1'b0}, '{1'b1, 1'b1, 13'h1fff, 1'b1}};
  logic core_clk, rst, psel, penable, pwrite, power_down_n, fanout_clock_in, halt_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, freq_select_straps, pci_clock_out;
  logic pready, pslverr, err, shared_pin_in, reference_clock_out, reference_clock_oe, mode_strap, straps_valid;
  logic [4:0] dual_pin_in, dual_pin_out, dual_pin_oe, pull_level;
  logic [12:0] fanout_clock_copies;
  logic cpu_clock_true, cpu_clock_complement, cpu_clock_complement_oe, cpu_chipset_clock;
  int mismatches = 0;
  int n_checks = 0;
  int m_off, m_on;

  strap_latch_sequencer #(.SELECT_CYCLES(SEL)) strap_latch_sequencer_i (.core_clk(core_clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dual_pin_in(dual_pin_in),
    .dual_pin_out(dual_pin_out), .dual_pin_oe(dual_pin_oe), .shared_pin_in(shared_pin_in),
    .reference_clock_out(reference_clock_out), .reference_clock_oe(reference_clock_oe),
    .power_down_n(power_down_n),
    .fanout_clock_in(fanout_clock_in), .fanout_clock_copies(fanout_clock_copies),
    .cpu_clock_true(cpu_clock_true), .cpu_clock_complement(cpu_clock_complement),
    .cpu_clock_complement_oe(cpu_clock_complement_oe), .cpu_chipset_clock(cpu_chipset_clock),
    .pci_clock_out(pci_clock_out), .freq_select_straps(freq_select_straps), .mode_strap(mode_strap),
    .straps_valid(straps_valid));
  sls_strap_board sls_strap_board_i (.pull_level(pull_level), .halt_n(halt_n), .dual_pin_out(dual_pin_out),
    .dual_pin_oe(dual_pin_oe), .reference_clock_out(reference_clock_out),
    .reference_clock_oe(reference_clock_oe), .dual_pin_in(dual_pin_in), .shared_pin_in(shared_pin_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // power cycle with a strap pattern, then follow the selection period
  task automatic power_up(input logic [4:0] p);
    int cnt;
    cnt = 0;
    @(posedge core_clk);
    rst <= 1'b1;
    pull_level <= p;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    do begin
      @(negedge core_clk);
      cnt++;
      chk(dual_pin_oe, 5'h00);
    end while (straps_valid !== 1'b1 && cnt < 200);
    chk(cnt, SEL + 2);
    chk({mode_strap, freq_select_straps}, p);
    @(negedge core_clk);
    chk(dual_pin_oe, 5'h1f);
    chk(reference_clock_oe, p[4]);
    @(posedge core_clk);
  endtask : power_up

  // cycles spanned by four cpu clock half periods, first phase skipped
  task automatic measure(output int m);
    logic last;
    m = 0;
    @(posedge cpu_clock_true);
    @(negedge core_clk);
    last = cpu_clock_true;
    for (int t = 0; t < 4 && m < 400; m++) begin
      @(negedge core_clk);
      if (cpu_clock_true !== last) t++;
      last = cpu_clock_true;
    end
  endtask : measure

  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    power_down_n = 1'b1;
    fanout_clock_in = 1'b0;
    halt_n = 1'b1;
    pull_level = 5'h16;
    power_up(5'h16);
    foreach (rows[i]) begin
      power_down_n <= rows[i].pdn;
      fanout_clock_in <= rows[i].fin;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      chk(fanout_clock_copies, rows[i].copies);
      chk(cpu_clock_complement_oe, rows[i].cmp_oe);
      chk(cpu_clock_complement, rows[i].pdn & ~cpu_clock_true);
      chk(pci_clock_out, {4{dual_pin_out[4]}});
      if (!rows[i].pdn) begin
        chk({cpu_clock_true, cpu_chipset_clock, pci_clock_out, dual_pin_out, reference_clock_out}, 12'h000);
      end
      @(posedge core_clk);
    end
    power_down_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h6d);
    power_down_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h2d);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h004, 32'hff);
    chk(err, 1'b0);
    pstrb <= 4'he;
    apb(1'b1, 12'h000, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[1:0], 2'h3);
    apb(1'b0, 12'h008, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    pull_level <= 5'h09;
    repeat (10) @(posedge core_clk);
    chk({mode_strap, freq_select_straps, straps_valid}, 6'h2d);
    apb(1'b1, 12'h000, 32'h0);
    measure(m_off);
    chk(m_off, 4 * (20 - 6));
    apb(1'b1, 12'h000, 32'h1);
    measure(m_on);
    chk(m_on, 4 * (20 - 6) + 2);
    power_up(5'h09);
    halt_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk({cpu_clock_true, cpu_chipset_clock, cpu_clock_complement_oe}, 3'h0);
    @(posedge core_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h93);
    halt_n <= 1'b1;
    results();
  end
endmodule : strap_latch_sequencer_tb
